// >>> verilog/serial_attenuator_control.sv
// Serial shift, latch and decode logic of a two-channel attenuator

// Contract
// - Codes 0x7F to 0xFF select mute
// - 0x7C=76dB, 0x7D=77dB, 0x7E=78dB deepest step
// - Held bits leave on serial output while shifting
// - Strobe rising captures the shift register word
// - Captured word sets addressed channel's tap
// - Unaddressed channels keep their setting
// - All channels mute after power-up
// - Muted channel disconnects input from output
// - Serial input sampled on serial clock rise
// - Bits accepted only while strobe low
// - Address byte then code byte, MSB first
// - Address 0 is channel one, 1 channel two
module serial_attenuator_control
  import atten_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               nrst_i,
  input  wire logic               sclk_i,
  input  wire logic               shift_n_i,
  input  wire logic               data_in_i,
  output logic                    data_out_o,
  output chan_t [NUM_CH-1:0]      ch_o
);

  // ----------------------------------------------------------------
  // Link domain: shift register on the serial clock
  // ----------------------------------------------------------------
  link_state_t l_q;
  link_state_t l_d;

  // Shift only while the strobe is low; MSB first in and out
  always_comb begin
    l_d = l_q;
    if (!shift_n_i) begin
      l_d.shift = {l_q.shift[WORD_W-2:0], data_in_i};
    end
  end

  // Link clock is parked at reset release, so no release synchroniser
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      l_q <= '{shift: SHIFT_RST};
    end else begin
      l_q <= l_d;
    end
  end

  // Older bits pass downstream in the order they arrived
  assign data_out_o = l_q.shift[WORD_W-1];

  // ----------------------------------------------------------------
  // System domain: strobe crossing, latch and decode
  // ----------------------------------------------------------------
  sys_state_t s_q;
  sys_state_t s_d;
  logic       latch_edge;
  word_t      word;

  // The word is quasi-static while the strobe is high, since no
  // shifting happens then, so it is sampled one edge after the
  // synchronised rise without a further crossing.
  // Limitation: a strobe fall with a link clock pulse in that window would tear the word.
  assign word       = word_t'(l_q.shift);
  assign latch_edge = s_q.sync[1] & ~s_q.strobe_prev;

  // Strobe synchroniser and per-channel update
  always_comb begin
    s_d             = s_q;
    s_d.sync        = {s_q.sync[0], shift_n_i};
    s_d.strobe_prev = s_q.sync[1];
    if (latch_edge) begin
      s_d.seen = 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        // Only a matching address touches a channel
        if (word.addr == ADDR_CH1 + 8'(i)) begin
          s_d.ch[i] = decode_code(word.code);
        end
      end
    end
  end

  // Reset puts every channel into mute
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{sync: 2'b11, strobe_prev: 1'b1, seen: 1'b0, ch: {NUM_CH{CHAN_RST}}};
    end else begin
      s_q <= s_d;
    end
  end

  // Mute flag drives the disconnect switch directly
  assign ch_o = s_q.ch;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Any mute code on channel one lands at full depth
  property p_mute_codes;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH1 && word.code >= MUTE_MIN
      |=> ch_o[0].mute && ch_o[0].atten_hdb == 8'hC8;
  endproperty
  a_mute_codes: assert property (p_mute_codes) else $error("mute code did not mute");

  // Deepest ladder step on channel two
  property p_deep_step;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH2 && word.code == 8'h7E
      |=> !ch_o[1].mute && ch_o[1].atten_hdb == 8'h9C && ch_o[1].tap == 7'h7E;
  endproperty
  a_deep_step: assert property (p_deep_step) else $error("code 0x7E not 78 dB");

  // First of the three deepest steps
  property p_coarse_step;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH1 && word.code == 8'h7C
      |=> ch_o[0].atten_hdb == 8'h98;
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("code 0x7C not 76 dB");

  // Half-dB region maps one code to one half step
  property p_fine_step;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH1 && word.code <= FINE_LAST
      |=> ch_o[0].atten_hdb == $past(word.code) && !ch_o[0].mute;
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("fine step decoded wrong");

  // Channel two only moves when addressed
  property p_hold_unaddressed;
    @(posedge mclk_i) disable iff (!nrst_i)
    !(latch_edge && word.addr == ADDR_CH2) |=> $stable(ch_o[1]);
  endproperty
  a_hold_unaddressed: assert property (p_hold_unaddressed) else $error("channel two changed");

  // Addresses past the last channel are ignored
  property p_bad_address;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr > ADDR_CH2 |=> $stable(ch_o);
  endproperty
  a_bad_address: assert property (p_bad_address) else $error("stray address changed a channel");

  // Power-up mute holds until the first latch
  property p_mute_until_word;
    @(posedge mclk_i) disable iff (!nrst_i)
    !s_q.seen |-> ch_o[0].mute && ch_o[1].mute;
  endproperty
  a_mute_until_word: assert property (p_mute_until_word) else $error("channel live before any word");

  // Strobe rise loads the shifted word into channel one
  property p_capture;
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(s_q.sync[1]) ##1 word.addr == ADDR_CH1 |=> ch_o[0].tap == $past(word.code[6:0]) || ch_o[0].mute;
  endproperty
  a_capture: assert property (p_capture) else $error("strobe rise did not load word");

  // Daisy-chain path: one bit in, one bit out per edge
  property p_shift_out;
    @(posedge sclk_i) disable iff (!nrst_i)
    !shift_n_i |=> data_out_o == $past(l_q.shift[WORD_W-2]) && l_q.shift[0] == $past(data_in_i);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("serial shift wrong");

  // Link clock with the strobe high shifts nothing
  property p_hold_shift;
    @(posedge sclk_i) disable iff (!nrst_i)
    shift_n_i |=> $stable(l_q.shift);
  endproperty
  a_hold_shift: assert property (p_hold_shift) else $error("shifted with strobe high");

  // ----------------------------------------------------------------
  // Assertions: decode corners and mute shape
  // ----------------------------------------------------------------
  // Middle of the three deepest steps
  property p_mid_step;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH1 && word.code == 8'h7D
      |=> ch_o[0].atten_hdb == 8'h9A && ch_o[0].tap == 7'h7D;
  endproperty
  a_mid_step: assert property (p_mid_step) else $error("code 0x7D not 77 dB");

  // Whole 1 dB region, counted up from 48 dB
  property p_coarse_range;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH1 && word.code >= COARSE_BASE && word.code < MUTE_MIN
      |=> int'(ch_o[0].atten_hdb) == int'(HDB_COARSE) + 2 * (int'($past(word.code)) - int'(COARSE_BASE));
  endproperty
  a_coarse_range: assert property (p_coarse_range) else $error("coarse step decoded wrong");

  // Mute codes on the second channel as well
  property p_mute_ch2;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH2 && word.code >= MUTE_MIN
      |=> ch_o[1].mute && ch_o[1].tap == TAP_MUTE && ch_o[1].atten_hdb == HDB_MUTE;
  endproperty
  a_mute_ch2: assert property (p_mute_ch2) else $error("mute code did not mute channel two");

  // Fine steps on the second channel
  property p_fine_ch2;
    @(posedge mclk_i) disable iff (!nrst_i)
    latch_edge && word.addr == ADDR_CH2 && word.code <= FINE_LAST
      |=> !ch_o[1].mute && ch_o[1].atten_hdb == $past(word.code) && ch_o[1].tap == $past(word.code[6:0]);
  endproperty
  a_fine_ch2: assert property (p_fine_ch2) else $error("fine step on channel two wrong");

  // Nothing moves while the synchronised strobe is low
  property p_quiet_strobe;
    @(posedge mclk_i) disable iff (!nrst_i)
    !s_q.sync[1] |=> $stable(ch_o);
  endproperty
  a_quiet_strobe: assert property (p_quiet_strobe) else $error("channel moved while shifting");

  // A muted channel always carries the isolating tap and full depth
  for (genvar g = 0; g < NUM_CH; g++) begin : g_mute_shape
    property p_mute_shape;
      @(posedge mclk_i) disable iff (!nrst_i)
      ch_o[g].mute |-> ch_o[g].tap == TAP_MUTE && ch_o[g].atten_hdb == HDB_MUTE;
    endproperty
    a_mute_shape: assert property (p_mute_shape) else $error("muted channel not isolated");
  end

endmodule : serial_attenuator_control

// >>> verilog/atten_pkg.sv
// Shared constants and types for the serial attenuator control block
package atten_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int            NUM_CH        = 2;
  localparam int            WORD_W        = 16;
  localparam int            BYTE_W        = 8;
  localparam logic [7:0]    ADDR_CH1      = 8'h00;  // First channel address
  localparam logic [7:0]    ADDR_CH2      = 8'h01;  // Second channel address

  // ----------------------------------------------------------------
  // Attenuation code decode
  // ----------------------------------------------------------------
  localparam logic [7:0]    FINE_LAST     = 8'h5F;  // Last 0.5 dB step
  localparam logic [7:0]    COARSE_BASE   = 8'h60;  // First 1 dB step, 48 dB
  localparam logic [7:0]    MUTE_MIN      = 8'h7F;  // This code and up mute
  localparam logic [7:0]    HDB_COARSE    = 8'h60;  // 48 dB in half-dB units
  localparam logic [7:0]    HDB_MUTE      = 8'hC8;  // 100 dB in half-dB units
  localparam logic [6:0]    TAP_MUTE      = 7'h7F;  // Tap index used while muted
  localparam logic [15:0]   SHIFT_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       mute;       // Input disconnected from output
    logic [6:0] tap;        // Ladder tap index
    logic [7:0] atten_hdb;  // Attenuation in 0.5 dB units
  } chan_t;

  localparam chan_t CHAN_RST = '{mute: 1'b1, tap: TAP_MUTE, atten_hdb: HDB_MUTE};

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] code;
  } word_t;

  typedef struct packed {
    logic [15:0] shift;
  } link_state_t;

  typedef struct packed {
    logic [1:0]               sync;
    logic                     strobe_prev;
    logic                     seen;
    chan_t [NUM_CH-1:0]       ch;
  } sys_state_t;

  // Code to tap setting; every code from MUTE_MIN upward is mute
  function automatic chan_t decode_code(input logic [7:0] code);
    chan_t r;
    r = CHAN_RST;
    if (code < MUTE_MIN) begin
      r.mute = 1'b0;
      r.tap  = code[6:0];
      if (code <= FINE_LAST) begin
        r.atten_hdb = code;
      end else begin
        r.atten_hdb = 8'((code - COARSE_BASE) << 1) + HDB_COARSE;
      end
    end
    return r;
  endfunction : decode_code

endpackage : atten_pkg

// >>> dv/link_ctl_model.sv
// Serial controller model that drives frames onto the attenuator link
module link_ctl_model (
  input  wire logic dout_i,
  output logic      sclk_o,
  output logic      shift_n_o,
  output logic      data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: strobe high, link clock parked low
  initial begin
    sclk_o    = 1'b0;
    shift_n_o = 1'b1;
    data_o    = 1'b0;
  end

  // One frame of nb bits; link clock runs only inside the frame
  task automatic send(input logic [31:0] w, input int nb, output logic [31:0] seen);
    seen = '0;
    shift_n_o = 1'b0;
    #7.3;
    for (int i = nb - 1; i >= 0; i--) begin
      data_o = w[i];
      #3;
      seen = {seen[30:0], dout_i};
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
    end
    #3;
    shift_n_o = 1'b1;
    data_o = ~data_o;  // Released line must not keep its last bit
  endtask : send

  // Link clock pulse with the strobe high, which the device must refuse;
  // the data line moves first so that a wrong shift would show
  task automatic stray_clock;
    data_o = ~data_o;
    #3;
    sclk_o = 1'b1;
    #3;
    sclk_o = 1'b0;
  endtask : stray_clock
endmodule : link_ctl_model

// >>> dv/serial_attenuator_control_tb.sv
// Self-checking bench for the serial attenuator control block
module serial_attenuator_control_tb import atten_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic               mclk_i = 1'b0;
  logic               nrst_i = 1'b0;
  logic               sclk, shift_n, din, dout;
  chan_t [NUM_CH-1:0] ch;
  chan_t              m [NUM_CH];
  logic [7:0]         a, cd;
  logic [15:0]        last;
  int                 n_errors = 0;
  int                 checks = 0;
  // Corners alternate channel one and channel two
  logic [7:0]         corner [8] = '{8'h7C, 8'h7E, 8'h7D, 8'h7F, 8'h5F, 8'h60, 8'hFF, 8'h00};

  // ------------------------------------------------------------
  // Clock, design and link partner
  // ------------------------------------------------------------
  always #5 mclk_i = ~mclk_i;

  serial_attenuator_control dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk), .shift_n_i(shift_n),
    .data_in_i(din), .data_out_o(dout), .ch_o(ch));
  link_ctl_model ctl_u (.dout_i(dout), .sclk_o(sclk), .shift_n_o(shift_n), .data_o(din));

  // Expected channel state for a code
  function automatic chan_t exp_ch(input logic [7:0] c);
    chan_t r;
    r = '{mute: 1'b0, tap: c[6:0], atten_hdb: c};
    if (c > 8'h5F) r.atten_hdb = 8'(96 + 2 * (c - 8'h60));
    if (c >= 8'h7F) r = '{mute: 1'b1, tap: 7'h7F, atten_hdb: 8'hC8};
    return r;
  endfunction : exp_ch

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // Main sequence: corner codes first, then random words
  // ------------------------------------------------------------
  // Both channels must read mute after any reset
  task automatic check_mute;
    for (int c = 0; c < NUM_CH; c++) begin
      m[c] = exp_ch(8'hFF);
      chk(ch[c], m[c]);
    end
  endtask : check_mute

  // One frame, then the chain output and both channels; a long frame
  // carries a leading word that must leave on the chain output intact
  task automatic run_frame(input logic [7:0] fa, input logic [7:0] fc, input int fn);
    logic [15:0] lead;
    logic [31:0] seen;
    lead = 16'($urandom);
    @(negedge mclk_i);
    ctl_u.send({lead, fa, fc}, fn, seen);
    chk((fn == 32) ? seen[31:16] : seen[15:0], last);
    if (fn == 32) begin
      chk(seen[15:0], lead);
    end
    last = {fa, fc};
    repeat (8) @(negedge mclk_i);
    if (fa < 8'h02) begin
      m[fa[0]] = exp_ch(fc);
    end
    chk(ch[0], m[0]);
    chk(ch[1], m[1]);
  endtask : run_frame

  initial begin
    void'($urandom(97095));
    last = SHIFT_RST;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i) nrst_i = 1'b1;
    check_mute();
    for (int k = 0; k < 40; k++) begin
      a  = (k < 8) ? 8'(k % 2) : 8'($urandom % 4);
      cd = (k < 8) ? corner[k] : 8'($urandom);
      // Every third frame is a lone word, as for a single device
      run_frame(a, cd, (k % 3 == 2) ? 16 : 32);
      // Refusal probe, well clear of the latch window
      if (k % 4 == 1) begin
        ctl_u.stray_clock();
      end
    end
    // Channel one live, then a mid-run reset must mute it again
    run_frame(ADDR_CH1, 8'h20, 16);
    @(negedge mclk_i) nrst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    nrst_i = 1'b1;
    last = SHIFT_RST;
    check_mute();
    run_frame(ADDR_CH2, 8'h10, 32);
    report_and_stop();
  end

  // Hang guard, well beyond forty-two frames
  initial begin
    #100us;
    n_errors++;
    report_and_stop();
  end
endmodule : serial_attenuator_control_tb
